// file: hdl/srd_top.sv
// The implementer's own choices: the AHB-Lite register port and the address map.
`include "srd_cfg.svh"
module srd_top #(
   parameter int unsigned PDIAG_MIN_CYC = `SRD_T_PDIAG_MIN_US * (`SRD_CLK_HZ / 1000000),
   parameter int unsigned PDIAG_MAX_CYC = `SRD_T_PDIAG_MAX_S * `SRD_CLK_HZ
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic ata_reset_n,
   input wire logic pm_active,
   input wire logic cmd_wr,
   input wire logic pdiag_n_i,
   input wire logic pdiag_n_drv,
   input wire logic intrq_drv,
   input wire logic iordy_drv,
   input wire logic dmarq_drv,
   input wire logic dd_drv,
   output logic pdiag_n_oe,
   output logic intrq_oe,
   output logic iordy_oe,
   output logic dmarq_oe,
   output logic dd_oe,
   output logic diag_start,
   input wire logic diag_done,
   input wire logic [6:0] diag_code,
   output logic mode_restore_go,
   input wire logic mode_restore_done,
   output logic hw_reset_go,
   output logic pm_wake
);

   localparam srd_pkg::srd_tmr_t MIN_CYC = PDIAG_MIN_CYC[`SRD_TMR_W-1:0];
   localparam srd_pkg::srd_tmr_t MAX_CYC = PDIAG_MAX_CYC[`SRD_TMR_W-1:0];

   function automatic logic [7:0] srd_sel(input logic [31:0] a);
      srd_sel = {a[7:2], 2'b00};
   endfunction : srd_sel

   // One compare shared by every register write strobe
   function automatic logic srd_hit(input logic wr, input logic [7:0] wa, input logic [7:0] a);
      srd_hit = wr && (wa == a);
   endfunction : srd_hit

   srd_pkg::srd_state_e state;
   srd_pkg::srd_state_e next_state;
   srd_pkg::srd_tmr_t tmr;
   logic wr_q;
   logic [7:0] wa_q;
   logic srst;
   logic nien;
   logic packet;
   logic dev1_seen;
   logic run_diag;
   logic bsy;
   logic drdy;
   logic [5:0] st_low;
   logic [7:0] err;
   logic [31:0] sig;
   logic [7:0] devhead;
   logic [7:0] settings;
   logic [7:0] udma;
   logic released;
   logic samp_on;
   logic pdiag_seen;
   logic diag_busy;
   logic [6:0] diag_res;
   logic rst_q;
   logic addr_ok;
   logic wr_devctl;
   logic wr_cfg;
   logic wr_status;
   logic wr_settings;
   logic wr_udma;
   logic srst_rise;
   logic hw_rst;
   logic timeout;
   logic fin;
   logic [7:0] st_read;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ok = hsel && hready && htrans[1];
   assign wr_devctl = srd_hit(wr_q, wa_q, `SRD_A_DEVCTL);
   assign wr_cfg = srd_hit(wr_q, wa_q, `SRD_A_CFG);
   assign wr_status = srd_hit(wr_q, wa_q, `SRD_A_STATUS);
   assign wr_settings = srd_hit(wr_q, wa_q, `SRD_A_SETTINGS);
   assign wr_udma = srd_hit(wr_q, wa_q, `SRD_A_UDMA);
   // Power management state does not gate the reset
   assign srst_rise = wr_devctl && hwdata[`SRD_B_SRST] && !srst;
   assign hw_rst = !ata_reset_n;
   assign timeout = (tmr >= MAX_CYC);
   assign st_read = {bsy, drdy, st_low};
   assign pm_wake = srst && pm_active;

   // Bus drivers stay off while the sequence owns the link
   assign pdiag_n_oe = pdiag_n_drv && !released;
   assign intrq_oe = intrq_drv && !released;
   assign iordy_oe = iordy_drv && !released;
   assign dmarq_oe = dmarq_drv && !released;
   assign dd_oe = dd_drv && !released;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
      end else begin
         wr_q <= addr_ok && hwrite;
         wa_q <= srd_sel(haddr);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (addr_ok && !hwrite) begin
         unique case (srd_sel(haddr))
            `SRD_A_DEVCTL: hrdata <= {29'h0, srst, nien, 1'b0};
            `SRD_A_CFG: hrdata <= {29'h0, run_diag, dev1_seen, packet};
            `SRD_A_STATUS: hrdata <= {24'h0, st_read};
            `SRD_A_ERROR: hrdata <= {24'h0, err};
            `SRD_A_SIG: hrdata <= sig;
            `SRD_A_DEVHEAD: hrdata <= {24'h0, devhead};
            `SRD_A_SETTINGS: hrdata <= {24'h0, settings};
            `SRD_A_UDMA: hrdata <= {24'h0, udma};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // A second set while already held is not a new edge and does not restart
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         srst <= 1'b0;
         nien <= 1'b0;
      end else if (wr_devctl) begin
         srst <= hwdata[`SRD_B_SRST];
         nien <= hwdata[`SRD_B_NIEN];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         packet <= 1'b0;
         dev1_seen <= 1'b0;
         run_diag <= 1'b0;
      end else if (wr_cfg) begin
         packet <= hwdata[`SRD_B_PACKET];
         dev1_seen <= hwdata[`SRD_B_DEV1];
         run_diag <= hwdata[`SRD_B_RUNDIAG];
      end
   end

   // Ultra DMA selection is never touched by the reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         udma <= 8'h00;
      end else if (wr_udma) begin
         udma <= hwdata[7:0];
      end
   end

   // A write in the same cycle as the revert wins, so a setting is not lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settings <= `SRD_SET_RST;
      end else if (wr_settings) begin
         settings <= hwdata[7:0];
      end else if (srst_rise && !packet) begin
         settings <= `SRD_SET_RST;
      end
   end

   always_comb begin
      next_state = state;
      fin = 1'b0;
      unique case (state)
         srd_pkg::SRD_IDLE: begin
         end
         srd_pkg::SRD_HOLD: begin
            if (!srst) begin
               next_state = srd_pkg::SRD_POST;
            end
         end
         srd_pkg::SRD_POST: begin
            // Diagnostics still running at the deadline are cut off
            if (!samp_on && (!diag_busy || timeout)) begin
               fin = 1'b1;
               next_state = packet ? srd_pkg::SRD_RESTORE : srd_pkg::SRD_IDLE;
            end
         end
         srd_pkg::SRD_RESTORE: begin
            if (mode_restore_done) begin
               next_state = srd_pkg::SRD_IDLE;
            end
         end
      endcase
      if (srst_rise) begin
         next_state = srd_pkg::SRD_HOLD;
      end
      if (hw_rst) begin
         next_state = srd_pkg::SRD_IDLE;
         fin = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= srd_pkg::SRD_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Counter parks at the limit so it cannot wrap into a false early window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tmr <= '0;
      end else if (state != srd_pkg::SRD_POST) begin
         tmr <= '0;
      end else if (!timeout) begin
         tmr <= tmr + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         samp_on <= 1'b0;
         pdiag_seen <= 1'b0;
      end else if (hw_rst || srst_rise) begin
         samp_on <= 1'b0;
         pdiag_seen <= 1'b0;
      end else if (state == srd_pkg::SRD_HOLD && !srst) begin
         samp_on <= dev1_seen;
         pdiag_seen <= 1'b0;
      end else if (samp_on) begin
         if (cmd_wr || timeout) begin
            samp_on <= 1'b0;
         end else if (tmr >= MIN_CYC && !pdiag_n_i) begin
            samp_on <= 1'b0;
            pdiag_seen <= 1'b1;
         end
      end
   end

   // Packet devices only run diagnostics when configured to
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         diag_busy <= 1'b0;
         diag_start <= 1'b0;
         diag_res <= `SRD_DIAG_NONE;
      end else begin
         diag_start <= srst_rise && !hw_rst && (!packet || run_diag);
         if (hw_rst) begin
            diag_busy <= 1'b0;
         end else if (srst_rise) begin
            diag_busy <= !packet || run_diag;
            diag_res <= `SRD_DIAG_NONE;
         end else if (diag_busy && diag_done) begin
            diag_busy <= 1'b0;
            diag_res <= diag_code;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err <= 8'h00;
      end else if (fin) begin
         err <= {dev1_seen && !pdiag_seen, diag_res};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sig <= 32'h00000000;
         devhead <= 8'h00;
      end else if (fin) begin
         sig <= packet ? `SRD_SIG_PKT : `SRD_SIG_ATA;
         devhead <= `SRD_DEVHEAD_SIG;
      end
   end

   // Software set of a low status bit wins over the hardware clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_low <= 6'h00;
      end else if (wr_status) begin
         st_low <= hwdata[5:0];
      end else if (fin) begin
         st_low <= st_low & ~(packet ? `SRD_CLR_PKT : `SRD_CLR_ATA);
      end
   end

   // Restart or pin reset raises BSY on the next edge, well inside 400 ns
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bsy <= 1'b0;
         drdy <= 1'b0;
      end else if (hw_rst || srst_rise) begin
         bsy <= 1'b1;
         drdy <= 1'b0;
      end else if (fin && !packet) begin
         bsy <= 1'b0;
         drdy <= 1'b1;
      end else if (state == srd_pkg::SRD_RESTORE && mode_restore_done) begin
         bsy <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         released <= 1'b0;
      end else if (hw_rst || srst_rise) begin
         released <= 1'b1;
      end else if (fin && !packet) begin
         released <= 1'b0;
      end else if (state == srd_pkg::SRD_RESTORE && mode_restore_done) begin
         released <= 1'b0;
      end
   end

   // Handoff only while a sequence runs; an idle pin reset is not ours
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_restore_go <= 1'b0;
         rst_q <= 1'b0;
         hw_reset_go <= 1'b0;
      end else begin
         mode_restore_go <= fin && packet;
         rst_q <= hw_rst;
         hw_reset_go <= hw_rst && !rst_q && state != srd_pkg::SRD_IDLE;
      end
   end

   logic unused_ok;
   assign unused_ok = ^{hsize, haddr[31:8], haddr[1:0]};

endmodule : srd_top

// file: hdl/srd_cfg.svh
`ifndef SRD_CFG_SVH
`define SRD_CFG_SVH
`define SRD_A_DEVCTL 8'h00
`define SRD_A_CFG 8'h04
`define SRD_A_STATUS 8'h08
`define SRD_A_ERROR 8'h0C
`define SRD_A_SIG 8'h10
`define SRD_A_DEVHEAD 8'h14
`define SRD_A_SETTINGS 8'h18
`define SRD_A_UDMA 8'h1C
`define SRD_B_SRST 2
`define SRD_B_NIEN 1
`define SRD_B_PACKET 0
`define SRD_B_DEV1 1
`define SRD_B_RUNDIAG 2
`define SRD_SIG_ATA 32'h00000101
`define SRD_SIG_PKT 32'hEB140101
`define SRD_DEVHEAD_SIG 8'h00
`define SRD_SET_RST 8'h00
`define SRD_DIAG_NONE 7'h01
`define SRD_CLR_ATA 6'h0D
`define SRD_CLR_PKT 6'h2D
`define SRD_CLK_HZ 20000000
`define SRD_T_PDIAG_MIN_US 1000
`define SRD_T_PDIAG_MAX_S 31
`define SRD_TMR_W 30
`endif

// file: hdl/srd_pkg.sv
`include "srd_cfg.svh"
package srd_pkg;
   typedef enum logic [1:0] {
      SRD_IDLE,
      SRD_HOLD,
      SRD_POST,
      SRD_RESTORE
   } srd_state_e;
   typedef logic [`SRD_TMR_W-1:0] srd_tmr_t;
endpackage : srd_pkg

// file: testbench/srd_properties.sv
module srd_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic ata_reset_n,
   input wire logic pm_active,
   input wire logic pdiag_n_drv,
   input wire logic pdiag_n_oe,
   input wire logic intrq_oe,
   input wire logic iordy_oe,
   input wire logic dmarq_oe,
   input wire logic dd_oe,
   input wire logic diag_start,
   input wire logic mode_restore_go,
   input wire logic hw_reset_go,
   input wire logic pm_wake
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rel;
      !pdiag_n_oe && !intrq_oe && !iordy_oe && !dmarq_oe && !dd_oe;
   endsequence
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   chk_diag_rel: assert property (diag_start |-> s_rel)
      else $error("diagnostics start while lines driven");
   chk_diag_pulse: assert property (diag_start |=> !diag_start)
      else $error("diagnostics start longer than one cycle");
   // Host holds the bit for far more than four cycles
   chk_hold_rel: assert property (diag_start |-> s_rel [*4])
      else $error("lines driven again while held");
   chk_restore_rel: assert property (mode_restore_go |-> s_rel)
      else $error("mode restore with lines driven");
   chk_hwrst_rel: assert property (hw_reset_go |-> s_rel)
      else $error("hardware reset handoff with lines driven");
   chk_hwrst_cause: assert property ($rose(hw_reset_go) |-> !$past(ata_reset_n))
      else $error("hardware reset handoff without reset pin");
   chk_hwrst_pulse: assert property (hw_reset_go |=> !hw_reset_go)
      else $error("hardware reset handoff not a pulse");
   chk_pm_wake: assert property (pm_wake |-> pm_active)
      else $error("wake without power management");
   chk_pdiag_idle: assert property (!pdiag_n_drv |-> !pdiag_n_oe)
      else $error("diag line driven without request");
endmodule : srd_chk
bind srd_top srd_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .ata_reset_n, .pm_active,
   .pdiag_n_drv, .pdiag_n_oe, .intrq_oe, .iordy_oe, .dmarq_oe, .dd_oe, .diag_start,
   .mode_restore_go, .hw_reset_go, .pm_wake);

// file: testbench/srd_far_model.sv
module srd_far_model (
   input wire logic hclk,
   input wire logic diag_start,
   input wire logic mode_restore_go,
   input wire logic dev1_ok,
   input wire logic [6:0] code,
   output logic diag_done,
   output logic [6:0] diag_code,
   output logic mode_restore_done,
   output logic pdiag_n_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [19:0] dq = '0;
   logic [2:0] rq = '0;
   always @(posedge hclk) begin
      dq <= {dq[18:0], diag_start};
      rq <= {rq[1:0], mode_restore_go};
   end
   // Slow diagnostics, quick mode restore
   assign diag_done = dq[19];
   // Code is only valid with done; inverse otherwise exposes a late capture
   assign diag_code = diag_done ? code : ~code;
   assign mode_restore_done = rq[2];
   // Pulled-up line, low only while a passing second device asserts it
   assign pdiag_n_i = !dev1_ok;
endmodule : srd_far_model

// file: testbench/tb.sv
`include "srd_cfg.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MAXC = 400;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ata_reset_n = 1, pm_active = 0;
   logic cmd_wr = 0, drv = 1, dev1_ok = 0, rd_d = 0, hreadyout, hresp;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, lfsr = 32'hCC89405D, u;
   logic [63:0] v;
   logic diag_start, diag_done, mode_restore_go, mode_restore_done, pdiag_n_i;
   logic [6:0] diag_code, code = '0;
   logic [63:0] q[$];
   int err_count = 0, cmp_count = 0;
   always #25 hclk = ~hclk;
   srd_top #(.PDIAG_MIN_CYC(4), .PDIAG_MAX_CYC(MAXC)) u_dut (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .ata_reset_n, .pm_active, .cmd_wr, .pdiag_n_i, .pdiag_n_drv(drv), .intrq_drv(drv),
      .iordy_drv(drv), .dmarq_drv(drv), .dd_drv(drv), .pdiag_n_oe(), .intrq_oe(), .iordy_oe(),
      .dmarq_oe(), .dd_oe(), .diag_start, .diag_done, .diag_code, .mode_restore_go,
      .mode_restore_done, .hw_reset_go(), .pm_wake());
   srd_far_model u_far (.hclk, .diag_start, .mode_restore_go, .dev1_ok, .code, .diag_done,
      .diag_code, .mode_restore_done, .pdiag_n_i);
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next
   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
   endtask : check
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   task ahb(input logic [31:0] a, input logic [31:0] d, input logic w);
      hsel <= 1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
   endtask : ahb
   task rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      q.push_back({m, e & m});
      ahb(a, 32'h0, 1'b0);
   endtask : rd
   task sr(input logic [31:0] cfg);
      ahb(`SRD_A_CFG, cfg, 1'b1);
      ahb(`SRD_A_STATUS, 32'h3F, 1'b1);
      rd(`SRD_A_STATUS, 32'h0, 32'h80);
      ahb(`SRD_A_DEVCTL, 32'h4, 1'b1);
      rd(`SRD_A_STATUS, 32'h80, 32'h80);
      repeat (100) @(posedge hclk);
      ahb(`SRD_A_DEVCTL, 32'h0, 1'b1);
   endtask : sr
   // Data phase read seen at its closing edge, oldest note first
   always @(posedge hclk) begin
      if (rd_d) begin
         v = q.pop_front();
         check(hrdata & v[63:32], v[31:0]);
      end
      rd_d <= hsel && htrans[1] && !hwrite && hreadyout;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      rd(`SRD_A_STATUS, 32'h0, 32'hC0);
      rd(`SRD_A_ERROR, 32'h0, 32'hFF);
      rd(32'h20, 32'h0, 32'hFFFFFFFF);
      lfsr = lfsr_next(lfsr);
      u = {24'h0, lfsr[7:0]};
      code <= lfsr[6:0];
      ahb(`SRD_A_UDMA, u, 1'b1);
      ahb(`SRD_A_SETTINGS, u, 1'b1);
      pm_active <= 1;
      sr(32'h0);
      repeat (40) @(posedge hclk);
      rd(`SRD_A_STATUS, 32'h72, 32'hFF);
      rd(`SRD_A_ERROR, {25'h0, code}, 32'hFF);
      rd(`SRD_A_SIG, `SRD_SIG_ATA, 32'hFFFFFFFF);
      rd(`SRD_A_UDMA, u, 32'hFF);
      rd(`SRD_A_SETTINGS, `SRD_SET_RST, 32'hFF);
      pm_active <= 0;
      for (int k = 0; k < 3; k++) begin
         dev1_ok <= (k == 1);
         sr(32'h6);
         if (k == 0) begin
            repeat (100) @(posedge hclk);
            ahb(`SRD_A_DEVCTL, 32'h4, 1'b1);
            repeat (100) @(posedge hclk);
            ahb(`SRD_A_DEVCTL, 32'h0, 1'b1);
            repeat (MAXC - 100) @(posedge hclk);
            rd(`SRD_A_STATUS, 32'h80, 32'h80);
         end
         if (k == 2) begin
            repeat (10) @(posedge hclk);
            cmd_wr <= 1;
            @(posedge hclk);
            cmd_wr <= 0;
            repeat (4) @(posedge hclk);
            rd(`SRD_A_STATUS, 32'h40, 32'hC0);
         end
         repeat (MAXC) @(posedge hclk);
         rd(`SRD_A_ERROR, {24'h0, k != 1, code}, 32'hFF);
      end
      dev1_ok <= 0;
      drv <= 0;
      ahb(`SRD_A_SETTINGS, u, 1'b1);
      sr(32'h1);
      repeat (40) @(posedge hclk);
      rd(`SRD_A_STATUS, 32'h12, 32'hFF);
      rd(`SRD_A_SIG, `SRD_SIG_PKT, 32'hFFFFFFFF);
      rd(`SRD_A_SETTINGS, u, 32'hFF);
      drv <= 1;
      repeat (100) @(posedge hclk);
      // Pin reset mid-hold hands over; a later clear must not finish it
      ahb(`SRD_A_CFG, 32'h0, 1'b1);
      ahb(`SRD_A_DEVCTL, 32'h4, 1'b1);
      repeat (20) @(posedge hclk);
      ata_reset_n <= 0;
      repeat (3) @(posedge hclk);
      ata_reset_n <= 1;
      repeat (100) @(posedge hclk);
      ahb(`SRD_A_DEVCTL, 32'h0, 1'b1);
      repeat (40) @(posedge hclk);
      rd(`SRD_A_STATUS, 32'h80, 32'h80);
      repeat (2) @(posedge hclk);
      final_report();
   end
endmodule : tb
